/* File: core/pic_command_port.sv */
`include "pic_cfg.svh"

// What this block does
// [R1] a write opens with start and write address; only our address is acked
// [R2] sub-address byte and data byte follow the address, each acked
// [R3] data byte lands in its holding latch as its ack is driven
// [R4] master resends address, sub-address and data per byte; no auto-increment
// [R5] held data survives repeated starts to other devices until stop
// [R6] stop copies holding latches into the active command latches
// [R7] read address acked, then eight status bits driven msb first
// [R8] reads need no stop; any start is accepted in any state
// [R9] four writable command bytes at sub-addresses zero to three
// [R10] power-up leaves every command bit at zero
// [R11] supply lockout or either power-down state clears all command bits
// [R12] byte 0 bits 0 and 1 enable ldo1 and ldo2
// [R13] byte 0 bits 2 to 4 pick burst or pulse-skip per buck
// [R14] byte 0 bits 6:5 pick common buck switch slew, 1 to 8 ns
// [R15] byte 1 bit 0 turns the led boost on
// [R16] byte 1 bits 1 (upper) and 2 (lower) set led ramp time
// [R17] byte 1 bits 4:3 pick boost mode; 11 must not be written
// [R18] byte 1 bits 6:5 pick the led dimming clock
// [R19] byte 1 bit 7 selects slow boost switch edge
// [R20] byte 2 bits 5:0 are the led current code; 7:6 ignored
// [R21] byte 3 holds dimming denominator in 3:0, numerator in 7:4
// [R22] byte 0 bit 7 is stored but drives nothing
// [R23] slave address 0001001, write and read forms both acked
// [R24] master keeps to sub-addresses zero to three
// [R25] status is snapshotted at the read address ack
// [R26] stop with no new data leaves latches; clears also empty holding latches
// [R27] foreign addresses get no ack; port idles until next start
module pic_command_port
	import pic_pkg::*;
(
	input  wire logic                   i_mclk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_scl,
	input  wire logic                   i_sda,
	output logic                        o_sda,
	output logic                        o_sda_oe,
	input  wire logic [`PIC_STAT_W-1:0] i_status,
	input  wire logic                   i_bus_logic_supply_low,
	input  wire logic                   i_power_down_state_one,
	input  wire logic                   i_power_down_state_two,
	output logic                        o_ldo1_enable,
	output logic                        o_ldo2_enable,
	output logic                        o_buck1_burst_select,
	output logic                        o_buck2_burst_select,
	output logic                        o_buck3_burst_select,
	output logic                        o_buck_slew_low,
	output logic                        o_buck_slew_high,
	output logic                        o_led_boost_enable,
	output logic                        o_ramp_time_high,
	output logic                        o_ramp_time_low,
	output logic                        o_boost_mode_low,
	output logic                        o_boost_mode_high,
	output logic                        o_dim_clock_low,
	output logic                        o_dim_clock_high,
	output logic                        o_boost_switch_slow_edge,
	output logic [5:0]                  o_led_current_code,
	output logic [3:0]                  o_dim_ratio_denominator,
	output logic [3:0]                  o_dim_ratio_numerator
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic addr_match(input logic [7:0] b);
		addr_match = (b[7:1] == `PIC_DEV_ADDR); // see [R23]
	endfunction

	function automatic logic is_rx(input pic_state_t s);
		is_rx = (s == PIC_ST_ADDR) || (s == PIC_ST_SUB) || (s == PIC_ST_DATA);
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [`PIC_PIN_W-1:0]  pin_s;
	logic [`PIC_STAT_W-1:0] status_s;

	// bus lines idle high, so they leave reset high
	pic_in_sync #(
		.WIDTH (`PIC_PIN_W),
		.INIT  (`PIC_PIN_RESET)
	) u_pin_sync (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_async ({i_power_down_state_two, i_power_down_state_one,
		           i_bus_logic_supply_low, i_sda, i_scl}),
		.o_sync  (pin_s)
	);

	// status comes from analog comparators, unrelated to our clock
	pic_in_sync #(
		.WIDTH (`PIC_STAT_W),
		.INIT  (`PIC_SNAP_RESET)
	) u_stat_sync (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_async (i_status),
		.o_sync  (status_s)
	);

	logic scl_s;
	logic sda_s;
	logic clr_s;

	assign scl_s = pin_s[`PIC_PIN_SCL];
	assign sda_s = pin_s[`PIC_PIN_SDA];
	// level clear, held as long as any source stays asserted
	assign clr_s = pin_s[`PIC_PIN_UVLO] | pin_s[`PIC_PIN_PD1] | pin_s[`PIC_PIN_PD2]; // see [R11]

	// ----------------------------------------
	// bus edge and condition detection
	// ----------------------------------------
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// previous samples of the synchronised lines
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// start and stop need scl high on both samples
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ----------------------------------------
	// serial state machine
	// ----------------------------------------
	pic_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [1:0] sub_q;
	logic [7:0] snap_q;
	logic       oe_q;
	logic       sda_q;

	// sda is open drain: the data level is always low, only the enable moves
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sda_q <= 1'b0;
		end else begin
			sda_q <= 1'b0;
		end
	end

	// bit counter and shift register move on scl rise, sda changes on fall
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= PIC_ST_IDLE;
			cnt_q   <= `PIC_CNT_ZERO;
			shift_q <= `PIC_CMD_RESET;
			sub_q   <= `PIC_REG_LDO_BUCK;
			snap_q  <= `PIC_SNAP_RESET;
			oe_q    <= 1'b0;
		end else if (clr_s) begin
			state_q <= PIC_ST_IDLE;
			cnt_q   <= `PIC_CNT_ZERO;
			oe_q    <= 1'b0;
		end else if (start_det) begin
			// any start resynchronises, mid-read or not
			state_q <= PIC_ST_ADDR; // see [R8]
			cnt_q   <= `PIC_CNT_ZERO;
			oe_q    <= 1'b0;
		end else if (stop_det) begin
			state_q <= PIC_ST_IDLE;
			cnt_q   <= `PIC_CNT_ZERO;
			oe_q    <= 1'b0;
		end else if (scl_rise) begin
			if (is_rx(state_q) || state_q == PIC_ST_READ) begin
				cnt_q <= cnt_q + `PIC_CNT_ONE;
			end
			if (is_rx(state_q) && cnt_q < `PIC_LAST_BIT) begin
				shift_q <= {shift_q[6:0], sda_s};
			end
		end else if (scl_fall) begin
			case (state_q)
				PIC_ST_ADDR: begin
					if (cnt_q == `PIC_LAST_BIT) begin
						if (addr_match(shift_q)) begin
							oe_q <= 1'b1; // see [R1]
							if (shift_q[0] == `PIC_RW_READ) begin
								snap_q <= status_s; // see [R25]
							end
						end else begin
							state_q <= PIC_ST_IGNORE; // see [R27]
						end
					end else if (cnt_q == `PIC_ACK_BIT) begin
						cnt_q <= `PIC_CNT_ZERO;
						if (shift_q[0] == `PIC_RW_READ) begin
							state_q <= PIC_ST_READ;
							oe_q    <= ~snap_q[`PIC_BYTE_MSB]; // see [R7]
						end else begin
							state_q <= PIC_ST_SUB;
							oe_q    <= 1'b0;
						end
					end
				end
				PIC_ST_SUB: begin
					if (cnt_q == `PIC_LAST_BIT) begin
						oe_q  <= 1'b1; // see [R2]
						sub_q <= shift_q[1:0]; // see [R9]
					end else if (cnt_q == `PIC_ACK_BIT) begin
						oe_q    <= 1'b0;
						cnt_q   <= `PIC_CNT_ZERO;
						state_q <= PIC_ST_DATA;
					end
				end
				PIC_ST_DATA: begin
					if (cnt_q == `PIC_LAST_BIT) begin
						oe_q <= 1'b1; // see [R2]
					end else if (cnt_q == `PIC_ACK_BIT) begin
						// one data byte per address, further bytes are ignored
						oe_q    <= 1'b0; // see [R4]
						state_q <= PIC_ST_IGNORE;
					end
				end
				PIC_ST_READ: begin
					if (cnt_q == `PIC_LAST_BIT) begin
						// hand sda back for the master's ack, which has no effect
						oe_q    <= 1'b0;
						state_q <= PIC_ST_IGNORE;
					end else begin
						snap_q <= {snap_q[6:0], 1'b0};
						oe_q   <= ~snap_q[`PIC_BYTE_NEXT]; // see [R7]
					end
				end
				default: begin
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// holding and command latches
	// ----------------------------------------
	pic_bank_t hold_q;
	pic_bank_t cmd_q;
	logic      pend_q;
	logic      data_ack;

	assign data_ack = scl_fall && state_q == PIC_ST_DATA && cnt_q == `PIC_LAST_BIT;

	// out-of-range sub-addresses alias onto the low two bits
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hold_q <= '0;
			pend_q <= 1'b0;
		end else if (clr_s) begin
			hold_q <= '0; // see [R26]
			pend_q <= 1'b0;
		end else if (data_ack && !start_det && !stop_det) begin
			hold_q[sub_q] <= shift_q; // see [R3]
			pend_q        <= 1'b1;
		end else if (stop_det) begin
			pend_q <= 1'b0;
		end
	end

	// only a stop commits; repeated starts leave everything held
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cmd_q <= '0; // see [R10]
		end else if (clr_s) begin
			cmd_q <= '0; // see [R11]
		end else if (stop_det && pend_q) begin
			cmd_q <= hold_q; // see [R6] see [R5] see [R26]
		end
	end

	// ----------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------
	assign o_sda    = sda_q;
	assign o_sda_oe = oe_q;

	// byte 0 bit 7 is kept but drives nothing, see [R22]
	assign o_ldo1_enable        = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_LDO1]; // see [R12]
	assign o_ldo2_enable        = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_LDO2]; // see [R12]
	assign o_buck1_burst_select = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_BUCK1]; // see [R13]
	assign o_buck2_burst_select = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_BUCK2]; // see [R13]
	assign o_buck3_burst_select = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_BUCK3]; // see [R13]
	assign o_buck_slew_low      = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_SLEW_LO]; // see [R14]
	assign o_buck_slew_high     = cmd_q[`PIC_REG_LDO_BUCK][`PIC_F0_SLEW_HI]; // see [R14]

	// mode 11 is passed through as written; the master must avoid it
	assign o_led_boost_enable       = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_ENABLE]; // see [R15]
	assign o_ramp_time_high         = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_RAMP_HI]; // see [R16]
	assign o_ramp_time_low          = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_RAMP_LO]; // see [R16]
	assign o_boost_mode_low         = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_MODE_LO]; // see [R17]
	assign o_boost_mode_high        = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_MODE_HI]; // see [R17]
	assign o_dim_clock_low          = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_CLK_LO]; // see [R18]
	assign o_dim_clock_high         = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_CLK_HI]; // see [R18]
	assign o_boost_switch_slow_edge = cmd_q[`PIC_REG_LED_CTL][`PIC_F1_SLOW]; // see [R19]

	assign o_led_current_code      = cmd_q[`PIC_REG_LED_CODE][`PIC_F2_CODE]; // see [R20]
	assign o_dim_ratio_denominator = cmd_q[`PIC_REG_DIM][`PIC_F3_DEN]; // see [R21]
	assign o_dim_ratio_numerator   = cmd_q[`PIC_REG_DIM][`PIC_F3_NUM]; // see [R21]

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	sequence s_byte_end(pic_state_t st);
		scl_fall && !clr_s && state_q == st && cnt_q == `PIC_LAST_BIT;
	endsequence

	sequence s_ack_end(pic_state_t st);
		scl_fall && !clr_s && state_q == st && cnt_q == `PIC_ACK_BIT;
	endsequence

	AST_OWN_ADDR_ACK: assert property ( // see [R1]
		s_byte_end(PIC_ST_ADDR) ##0 addr_match(shift_q) |=> oe_q
	) else $error("own address not acknowledged");
	AST_FOREIGN_NO_ACK: assert property ( // see [R27]
		s_byte_end(PIC_ST_ADDR) ##0 !addr_match(shift_q)
		|=> !oe_q && state_q == PIC_ST_IGNORE
	) else $error("foreign address acknowledged");
	AST_SUB_DATA_ACK: assert property ( // see [R2]
		(s_byte_end(PIC_ST_SUB) or s_byte_end(PIC_ST_DATA)) |=> oe_q
	) else $error("sub-address or data byte not acknowledged");
	AST_HOLD_ON_ACK: assert property ( // see [R3]
		s_byte_end(PIC_ST_DATA) |=> hold_q[$past(sub_q)] == $past(shift_q) && pend_q
	) else $error("data byte not held at its acknowledge");
	AST_READ_SNAPSHOT: assert property ( // see [R25]
		s_byte_end(PIC_ST_ADDR) ##0 addr_match(shift_q) && shift_q[0]
		|=> snap_q == $past(status_s)
	) else $error("status not captured at read acknowledge");
	AST_READ_MSB_FIRST: assert property ( // see [R7]
		s_ack_end(PIC_ST_ADDR) ##0 shift_q[0] && !start_det && !stop_det
		|=> state_q == PIC_ST_READ && oe_q == ~snap_q[`PIC_BYTE_MSB]
	) else $error("first read bit is not the status msb");
	AST_START_ANYWHERE: assert property ( // see [R8]
		start_det && !clr_s |=> state_q == PIC_ST_ADDR && cnt_q == `PIC_CNT_ZERO && !oe_q
	) else $error("start not accepted");
	AST_REPEAT_KEEPS: assert property ( // see [R5]
		start_det && !clr_s |=> $stable(hold_q) && $stable(cmd_q) && $stable(pend_q)
	) else $error("repeated start disturbed held data");
	AST_STOP_LOADS: assert property ( // see [R6]
		stop_det && pend_q && !clr_s |=> cmd_q == $past(hold_q) && !pend_q
	) else $error("stop did not load command latches");
	AST_STOP_NO_DATA: assert property ( // see [R26]
		stop_det && !pend_q && !clr_s |=> $stable(cmd_q)
	) else $error("empty stop changed command latches");
	AST_CLEAR_ALL: assert property ( // see [R11]
		clr_s |=> cmd_q == '0 && hold_q == '0 && !o_sda_oe
	) else $error("clear left command bits set");

endmodule

/* File: shared/pic_cfg.svh */
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// ----------------------------------------
// bus address and bit counting
// ----------------------------------------
`define PIC_DEV_ADDR     7'h09
`define PIC_RW_READ      1'b1
`define PIC_CNT_ZERO     4'h0
`define PIC_CNT_ONE      4'h1
`define PIC_LAST_BIT     4'h8
`define PIC_ACK_BIT      4'h9

// ----------------------------------------
// command byte indexes and reset values
// ----------------------------------------
`define PIC_REG_LDO_BUCK 2'h0
`define PIC_REG_LED_CTL  2'h1
`define PIC_REG_LED_CODE 2'h2
`define PIC_REG_DIM      2'h3
`define PIC_CMD_RESET    8'h00
`define PIC_SNAP_RESET   8'h00

// ----------------------------------------
// field positions, ldo and buck byte
// ----------------------------------------
`define PIC_F0_LDO1      0
`define PIC_F0_LDO2      1
`define PIC_F0_BUCK1     2
`define PIC_F0_BUCK2     3
`define PIC_F0_BUCK3     4
`define PIC_F0_SLEW_LO   5
`define PIC_F0_SLEW_HI   6

// ----------------------------------------
// field positions, led bytes and status read bits
// ----------------------------------------
`define PIC_F1_ENABLE    0
`define PIC_F1_RAMP_HI   1
`define PIC_F1_RAMP_LO   2
`define PIC_F1_MODE_LO   3
`define PIC_F1_MODE_HI   4
`define PIC_F1_CLK_LO    5
`define PIC_F1_CLK_HI    6
`define PIC_F1_SLOW      7
`define PIC_F2_CODE      5:0
`define PIC_F3_DEN       3:0
`define PIC_F3_NUM       7:4
`define PIC_BYTE_MSB     7
`define PIC_BYTE_NEXT    6

// ----------------------------------------
// synchroniser lanes
// ----------------------------------------
`define PIC_PIN_W        5
`define PIC_PIN_SCL      0
`define PIC_PIN_SDA      1
`define PIC_PIN_UVLO     2
`define PIC_PIN_PD1      3
`define PIC_PIN_PD2      4
`define PIC_PIN_RESET    5'h03
`define PIC_STAT_W       8

`endif

/* File: shared/pic_pkg.sv */
package pic_pkg;

	// ----------------------------------------
	// serial port states
	// ----------------------------------------
	typedef enum logic [2:0] {
		PIC_ST_IDLE,
		PIC_ST_ADDR,
		PIC_ST_SUB,
		PIC_ST_DATA,
		PIC_ST_READ,
		PIC_ST_IGNORE
	} pic_state_t;

	typedef logic [3:0][7:0] pic_bank_t;

endpackage

/* File: core/pic_in_sync.sv */
`include "pic_cfg.svh"

// ----------------------------------------
// two-flop synchroniser bank
// ----------------------------------------
module pic_in_sync #(
	parameter int              WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds only the second
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

/* File: testbench/pic_bus_master.sv */
// ----------------------------------------
// bus master model, open-drain data line
// ----------------------------------------
module pic_bus_master (
	input  wire logic i_mclk,
	input  wire logic i_sda_oe,
	input  wire logic i_sda_dev,
	output logic      o_scl,
	output logic      o_sda
);
	timeunit 1ns;
	timeprecision 1ps;

	logic sda_rel;

	// pull-up wins unless a party drives; the device level counts only while enabled
	assign o_sda = sda_rel & (i_sda_oe ? i_sda_dev : 1'b1);

	// bus idles with both lines high
	initial begin
		o_scl   = 1'b1;
		sda_rel = 1'b1;
	end

	// quarter of a 160 ns bus clock, moves only on falling mclk edges
	task automatic quarter();
		repeat (5) @(negedge i_mclk);
	endtask

	// start or repeated start; scl left low
	task automatic start();
		sda_rel = 1'b1;
		quarter();
		o_scl = 1'b1;
		quarter();
		sda_rel = 1'b0;
		quarter();
		o_scl = 1'b0;
		quarter();
	endtask

	// stop; clock stands high afterwards
	task automatic stop();
		sda_rel = 1'b0;
		quarter();
		o_scl = 1'b1;
		quarter();
		sda_rel = 1'b1;
		quarter();
	endtask

	// one bit; wire sampled late in the high phase
	task automatic bit_xfer(input logic b, output logic r);
		sda_rel = b;
		quarter();
		o_scl = 1'b1;
		quarter();
		quarter();
		r = o_sda;
		o_scl = 1'b0;
		quarter();
	endtask

	// byte msb first, then the ack clock with sda released
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
		end
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask

	// one status byte; answered with a nack the device ignores
	task automatic get_byte(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, r);
			d[i] = r;
		end
		bit_xfer(1'b1, r);
	endtask
endmodule

/* File: testbench/pic_command_port_tb.sv */
module pic_command_port_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic        i_mclk;
	logic        i_rst_b;
	logic [7:0]  status;
	logic [2:0]  clr;
	wire         scl;
	wire         sda;
	wire         sda_oe;
	wire         sda_dev;
	wire  [28:0] got;
	logic [7:0]  hold [4];
	logic [7:0]  bank [4];
	logic [7:0]  corner [4] = '{8'h80, 8'he7, 8'hc0, 8'hff};
	int          n_mismatch;
	int          checked;

	pic_command_port i_dut (
		.i_mclk                   (i_mclk),
		.i_rst_b                  (i_rst_b),
		.i_scl                    (scl),
		.i_sda                    (sda),
		.o_sda                    (sda_dev),
		.o_sda_oe                 (sda_oe),
		.i_status                 (status),
		.i_bus_logic_supply_low   (clr[0]),
		.i_power_down_state_one   (clr[1]),
		.i_power_down_state_two   (clr[2]),
		.o_ldo1_enable            (got[22]),
		.o_ldo2_enable            (got[23]),
		.o_buck1_burst_select     (got[24]),
		.o_buck2_burst_select     (got[25]),
		.o_buck3_burst_select     (got[26]),
		.o_buck_slew_low          (got[27]),
		.o_buck_slew_high         (got[28]),
		.o_led_boost_enable       (got[14]),
		.o_ramp_time_high         (got[15]),
		.o_ramp_time_low          (got[16]),
		.o_boost_mode_low         (got[17]),
		.o_boost_mode_high        (got[18]),
		.o_dim_clock_low          (got[19]),
		.o_dim_clock_high         (got[20]),
		.o_boost_switch_slow_edge (got[21]),
		.o_led_current_code       (got[13:8]),
		.o_dim_ratio_denominator  (got[3:0]),
		.o_dim_ratio_numerator    (got[7:4])
	);

	pic_bus_master i_bus (
		.i_mclk    (i_mclk),
		.i_sda_oe  (sda_oe),
		.i_sda_dev (sda_dev),
		.o_scl     (scl),
		.o_sda     (sda)
	);

	// ----------------------------------------
	// expectations and comparisons
	// ----------------------------------------
	// unused bits (byte0 bit7, byte2 bits 7:6) must never reach a pin
	function automatic logic [28:0] expect_pins(input logic [7:0] b0, b1, b2, b3);
		return {b0[6:0], b1, b2[5:0], b3};
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic chk_pins();
		logic [31:0] exp;
		exp = {3'h0, expect_pins(bank[0], bank[1], bank[2], bank[3])};
		chk("pins", exp, {3'h0, got});
	endtask

	// full address, sub-address, data cycle; no stop
	task automatic wr(input logic [1:0] sub, input logic [7:0] d);
		logic ack;
		i_bus.start();
		i_bus.put_byte(8'h12, ack);
		chk("write_addr_ack", 1, ack);
		i_bus.put_byte({6'h00, sub}, ack);
		chk("sub_ack", 1, ack);
		i_bus.put_byte(d, ack);
		chk("data_ack", 1, ack);
		hold[sub] = d;
	endtask

	task automatic commit();
		i_bus.stop();
		bank = hold;
		chk_pins();
	endtask

	// status snapshot must survive a change after the address ack
	task automatic rd();
		logic       ack;
		logic [7:0] snap;
		logic [7:0] d;
		snap = status;
		i_bus.start();
		i_bus.put_byte(8'h13, ack);
		chk("read_addr_ack", 1, ack);
		status = ~snap;
		i_bus.get_byte(d);
		chk("status", snap, d);
	endtask

	task automatic end_sim();
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	// cuts a hung bus short
	initial begin
		repeat (100000) @(posedge i_mclk);
		n_mismatch++;
		end_sim();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [1:0] sub;
		logic [7:0] d;
		logic       ack;
		i_rst_b    = 1'b0;
		status     = 8'h00;
		clr        = 3'h0;
		n_mismatch = 0;
		checked    = 0;
		foreach (hold[k]) begin
			hold[k] = 8'h00;
			bank[k] = 8'h00;
		end
		void'($urandom(32'h9cd4));
		repeat (5) @(negedge i_mclk);
		i_rst_b = 1'b1;
		repeat (5) @(negedge i_mclk);
		chk_pins();
		// corner bytes first, then random; held data must not show before stop
		for (int n = 0; n < 16; n++) begin
			sub = (n < 4) ? n[1:0] : 2'($urandom);
			d = (n < 4) ? corner[n] : 8'($urandom);
			if (sub == 2'h1 && d[4:3] == 2'b11) begin
				d[4] = 1'b0;
			end
			wr(sub, d);
			if (n % 3 == 2) begin
				chk_pins();
				commit();
			end
		end
		// foreign addresses between the last write and its stop
		for (int n = 0; n < 3; n++) begin
			i_bus.start();
			i_bus.put_byte(8'h40 + 8'(2 * n), ack);
			chk("foreign_ack", 0, ack);
			i_bus.put_byte(8'h00, ack);
			chk("foreign_data_ack", 0, ack);
		end
		commit();
		// empty stop leaves the latches alone
		i_bus.start();
		i_bus.stop();
		chk_pins();
		// reads joined by repeated starts, no stop between
		for (int n = 0; n < 3; n++) begin
			status = 8'($urandom);
			repeat (4) @(negedge i_mclk);
			rd();
		end
		wr(2'h2, 8'($urandom));
		commit();
		// each clear source empties both latch sets
		for (int c = 0; c < 3; c++) begin
			wr(2'h0, 8'h7f);
			commit();
			wr(2'h3, 8'h5a);
			clr[c] = 1'b1;
			repeat (10) @(negedge i_mclk);
			foreach (hold[k]) begin
				hold[k] = 8'h00;
			end
			bank = hold;
			chk_pins();
			clr[c] = 1'b0;
			repeat (10) @(negedge i_mclk);
			commit();
			// a fresh write must not drag back bytes held before the clear
			wr(2'h1, 8'h00);
			commit();
		end
		end_sim();
	end
endmodule
